// File: rtl/hpxm_top.sv
`timescale 1ns/1ns
`default_nettype none
module hpxm_top #(
  parameter logic [19:0] UPDATE_CYC = hpxm_pkg::UPDATE_CYC  // Cycles per update period
) (
  input  wire logic        clk,                   // Core clock, 25 MHz
  input  wire logic        resetn,                // Async reset, active low
  input  wire logic        expander_irq_n,        // Shared expander interrupt pin
  input  wire logic        gpio_alt_mode,         // Pin set to alternate function
  input  wire logic        fund_rst,              // Fundamental reset in progress
  input  wire logic        addr_cfg_valid,        // Expander addresses loaded
  input  wire logic [55:0] exp_addr,              // 7-bit address per expander
  input  wire logic [15:0] slot_attn_indicator,   // Internal attention indicator
  input  wire logic [15:0] slot_power_indicator,  // Internal power indicator
  input  wire logic [15:0] slot_power_enable,     // Internal power enable
  input  wire logic [15:0] slot_reset_n,          // Internal slot reset
  output logic [15:0]      slot_attn_button_n,    // Read attention button
  output logic [15:0]      slot_presence_n,       // Read presence detect
  output logic [15:0]      slot_power_fault_n,    // Read power fault
  output logic [15:0]      slot_power_good_n,     // Read power good
  output logic             cmd_valid,             // Transaction request
  input  wire logic        cmd_ready,             // SMBus engine takes request
  output logic             cmd_write,             // 1 write, 0 read
  output logic [6:0]       cmd_addr,              // Expander address
  output logic [7:0]       cmd_reg,               // First expander register
  output logic [15:0]      cmd_data,              // Two-byte write data
  input  wire logic        rsp_valid,             // Transaction finished
  input  wire logic        rsp_error,             // Transaction failed
  input  wire logic [15:0] rsp_data,              // Two-byte read data
  input  wire logic [1:0]  status_clr,            // Clear status bits
  output logic [1:0]       smbus_status_reg       // Sticky write/read error
);
  localparam int NEXP = hpxm_pkg::NEXP;

  hpxm_pkg::hpxm_state_t state_q;
  hpxm_pkg::hpxm_job_t   job_q, init_step_q, pick_job;
  logic [2:0]   rr_q;
  logic [2:0]   cur_q;
  logic         init_job_q;
  logic         running_q;
  logic         fund_rst_q;
  logic [7:0]   init_need_q;
  logic [7:0]   read_need_q;
  logic [19:0]  rd_cnt_q;
  logic [1:0]   status_q;
  logic         irq_n_s;
  logic [15:0]  out_word [NEXP];
  logic [15:0]  shadow_q [NEXP];
  logic [7:0]   in_q     [NEXP];
  logic [19:0]  wr_cnt_q [NEXP];
  logic [6:0]   addr_arr [NEXP];
  logic [7:0]   wr_ok, need;

  hpxm_sync u_irq_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (expander_irq_n),
    .q      (irq_n_s)
  );

  wire irq_req      = gpio_alt_mode & ~irq_n_s;
  wire start_init   = fund_rst_q & ~fund_rst & addr_cfg_valid;
  wire rd_ok        = (rd_cnt_q == UPDATE_CYC);
  wire sweep_start  = running_q & irq_req & rd_ok &
                      (read_need_q == 8'h00) & (init_need_q == 8'h00);
  wire cmd_fire     = (state_q == hpxm_pkg::HPXM_ISSUE) & cmd_ready;
  wire rsp_take     = (state_q == hpxm_pkg::HPXM_WAIT) & rsp_valid;
  wire rsp_good     = rsp_take & ~rsp_error;
  wire init_more    = init_job_q & (job_q != hpxm_pkg::HPXM_JOB_READ);
  wire pick_fire    = (state_q == hpxm_pkg::HPXM_IDLE) & running_q & ~fund_rst & need[rr_q];
  wire job_done     = rsp_take & ~init_more;
  wire wr_ok_cur    = wr_ok[cur_q];
  wire [15:0] out_word_cur = out_word[rr_q];
  wire [1:0]  err_set;
  assign err_set[hpxm_pkg::ST_WR_ERR] = rsp_take & rsp_error & cmd_write;
  assign err_set[hpxm_pkg::ST_RD_ERR] = rsp_take & rsp_error & ~cmd_write;

  assign pick_job = init_need_q[rr_q] ? init_step_q :
                    read_need_q[rr_q] ? hpxm_pkg::HPXM_JOB_READ : hpxm_pkg::HPXM_JOB_WRITE;
  assign cmd_valid        = (state_q == hpxm_pkg::HPXM_ISSUE);
  assign smbus_status_reg = status_q;

  genvar e;
  generate
    for (e = 0; e < NEXP; e++) begin : g_exp
      localparam int SA = (e / 2) * 4 + (e % 2);
      localparam int SB = SA + 2;
      wire hit = (cur_q == 3'(e));
      assign addr_arr[e] = exp_addr[e*7 +: 7];
      // Output nibble above input nibble, slot x low byte, slot x+2 high byte
      assign out_word[e] = {slot_reset_n[SB], slot_power_enable[SB],
                            slot_power_indicator[SB], slot_attn_indicator[SB],
                            hpxm_pkg::IN_FILL,
                            slot_reset_n[SA], slot_power_enable[SA],
                            slot_power_indicator[SA], slot_attn_indicator[SA],
                            hpxm_pkg::IN_FILL};
      assign slot_attn_button_n[SA] = in_q[e][0];
      assign slot_presence_n[SA]    = in_q[e][1];
      assign slot_power_fault_n[SA] = in_q[e][2];
      assign slot_power_good_n[SA]  = in_q[e][3];
      assign slot_attn_button_n[SB] = in_q[e][4];
      assign slot_presence_n[SB]    = in_q[e][5];
      assign slot_power_fault_n[SB] = in_q[e][6];
      assign slot_power_good_n[SB]  = in_q[e][7];
      assign wr_ok[e] = (wr_cnt_q[e] == UPDATE_CYC);
      // Mismatch drives a write; a failed write retries next period
      assign need[e] = init_need_q[e] | read_need_q[e] |
                       ((out_word[e] != shadow_q[e]) & wr_ok[e]);
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          wr_cnt_q[e] <= UPDATE_CYC;
          shadow_q[e] <= 16'h0000;
          in_q[e]     <= hpxm_pkg::IN_IDLE;
        end else begin
          if (hit && cmd_fire && cmd_write)
            wr_cnt_q[e] <= 20'h0_0000;
          else if (!wr_ok[e])
            wr_cnt_q[e] <= wr_cnt_q[e] + 20'h0_0001;
          if (hit && rsp_good && job_q == hpxm_pkg::HPXM_JOB_WRITE)
            shadow_q[e] <= cmd_data;
          if (hit && rsp_good && job_q == hpxm_pkg::HPXM_JOB_READ)
            in_q[e] <= {rsp_data[11:8], rsp_data[3:0]};
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= hpxm_pkg::HPXM_IDLE;
      job_q       <= hpxm_pkg::HPXM_JOB_READ;
      init_step_q <= hpxm_pkg::HPXM_JOB_POLAR;
      init_job_q  <= 1'b0;
      rr_q        <= 3'h0;
      cur_q       <= 3'h0;
      cmd_write   <= 1'b0;
      cmd_addr    <= 7'h00;
      cmd_reg     <= 8'h00;
      cmd_data    <= 16'h0000;
    end else begin
      unique case (state_q)
        hpxm_pkg::HPXM_IDLE: begin
          if (pick_fire) begin
            state_q    <= hpxm_pkg::HPXM_ISSUE;
            cur_q      <= rr_q;
            job_q      <= pick_job;
            init_job_q <= init_need_q[rr_q];
            cmd_addr   <= addr_arr[rr_q];
            cmd_write  <= (pick_job != hpxm_pkg::HPXM_JOB_READ);
            unique case (pick_job)
              hpxm_pkg::HPXM_JOB_POLAR: begin
                cmd_reg  <= hpxm_pkg::REG_POLAR;
                cmd_data <= hpxm_pkg::POLAR_NONE;
              end
              hpxm_pkg::HPXM_JOB_WRITE: begin
                cmd_reg  <= hpxm_pkg::REG_OUTPUT;
                cmd_data <= out_word_cur;
              end
              hpxm_pkg::HPXM_JOB_CONFIG: begin
                cmd_reg  <= hpxm_pkg::REG_CONFIG;
                cmd_data <= hpxm_pkg::CONFIG_DIR;
              end
              hpxm_pkg::HPXM_JOB_READ: begin
                cmd_reg  <= hpxm_pkg::REG_INPUT;
                cmd_data <= hpxm_pkg::READ_FILL;
              end
            endcase
          end else if (!(running_q && need[rr_q])) begin
            rr_q <= rr_q + 3'h1;
          end
        end
        hpxm_pkg::HPXM_ISSUE: begin
          if (cmd_ready)
            state_q <= hpxm_pkg::HPXM_WAIT;
        end
        hpxm_pkg::HPXM_WAIT: begin
          if (rsp_valid) begin
            state_q <= hpxm_pkg::HPXM_IDLE;
            if (init_more) begin
              init_step_q <= (job_q == hpxm_pkg::HPXM_JOB_POLAR) ? hpxm_pkg::HPXM_JOB_WRITE :
                             (job_q == hpxm_pkg::HPXM_JOB_WRITE) ? hpxm_pkg::HPXM_JOB_CONFIG :
                                                                   hpxm_pkg::HPXM_JOB_READ;
            end else begin
              init_step_q <= hpxm_pkg::HPXM_JOB_POLAR;
              rr_q        <= cur_q + 3'h1;
            end
          end
        end
        default: state_q <= hpxm_pkg::HPXM_IDLE;
      endcase
    end
  end

  // Fundamental reset only stops new work; expander outputs keep their state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fund_rst_q  <= 1'b1;
      running_q   <= 1'b0;
      init_need_q <= 8'h00;
      read_need_q <= 8'h00;
      rd_cnt_q    <= UPDATE_CYC;
      status_q    <= 2'b00;
    end else begin
      fund_rst_q <= fund_rst;
      if (fund_rst)
        running_q <= 1'b0;
      else if (start_init)
        running_q <= 1'b1;
      if (start_init)
        init_need_q <= hpxm_pkg::ALL_EXP;
      else if (job_done && init_job_q)
        init_need_q[cur_q] <= 1'b0;
      if (sweep_start)
        read_need_q <= hpxm_pkg::ALL_EXP;
      else if (job_done && !init_job_q && job_q == hpxm_pkg::HPXM_JOB_READ)
        read_need_q[cur_q] <= 1'b0;
      if (sweep_start)
        rd_cnt_q <= 20'h0_0000;
      else if (!rd_ok)
        rd_cnt_q <= rd_cnt_q + 20'h0_0001;
      status_q <= (status_q & ~status_clr) | err_set;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  irq_gate_a: assert property (!gpio_alt_mode |-> !sweep_start)
    else $error("read sweep started without alternate function");
  read_all_a: assert property (sweep_start |=> read_need_q == 8'hFF)
    else $error("sweep did not mark every expander");
  write_rate_a: assert property (cmd_fire && cmd_write && !init_job_q |-> wr_ok_cur)
    else $error("expander written inside update period");
  read_rate_a: assert property (sweep_start |-> rd_cnt_q == UPDATE_CYC)
    else $error("inputs read inside update period");
  one_job_a: assert property (cmd_fire |=> !cmd_valid && state_q == hpxm_pkg::HPXM_WAIT)
    else $error("second request before response");
  rr_next_a: assert property (job_done |=> rr_q == $past(cur_q) + 3'h1)
    else $error("round robin did not move on");
  err_sticky_a: assert property (rsp_take && rsp_error |=> smbus_status_reg != 2'b00)
    else $error("error not recorded");
  init_go_a: assert property (start_init |=> running_q && init_need_q == 8'hFF)
    else $error("init not started after reset");
  init_data_a: assert property (pick_fire && pick_job == hpxm_pkg::HPXM_JOB_WRITE
                                |=> cmd_data == $past(out_word_cur))
    else $error("write data not current at start");
  fund_hold_a: assert property (fund_rst && state_q == hpxm_pkg::HPXM_IDLE |=> !cmd_valid)
    else $error("transaction started in fundamental reset");
  polar_zero_a: assert property (cmd_valid && cmd_reg == hpxm_pkg::REG_POLAR
                                 |-> cmd_data == 16'h0000)
    else $error("polarity register not zero");
  irq_sync_a: assert property ((gpio_alt_mode && !expander_irq_n) [*3] |-> irq_req)
    else $error("low interrupt not seen after sync");

  sweep_c: cover property (sweep_start);
  write_c: cover property (cmd_fire && cmd_write && !init_job_q);
  error_c: cover property (rsp_take && rsp_error);
endmodule : hpxm_top
`default_nettype wire

// File: rtl/hpxm_sync.sv
package hpxm_pkg;
  localparam int          NEXP       = 8;
  localparam int          NSLOT      = 16;
  localparam int          ADDR_W     = 7;
  localparam int          CLK_HZ     = 25_000_000;
  localparam int          UPDATE_MS  = 40;
  // Least interval in whole cycles: integer division truncates, no rounding up
  localparam int          UPDATE_INT = (CLK_HZ / 1000 * UPDATE_MS + 0) ;
  localparam logic [19:0] UPDATE_CYC = 20'(UPDATE_INT);
  localparam logic [7:0]  REG_INPUT  = 8'h00;
  localparam logic [7:0]  REG_OUTPUT = 8'h02;
  localparam logic [7:0]  REG_POLAR  = 8'h04;
  localparam logic [7:0]  REG_CONFIG = 8'h06;
  localparam logic [15:0] POLAR_NONE = 16'h0000;
  localparam logic [15:0] CONFIG_DIR = 16'h0F0F;
  localparam logic [15:0] READ_FILL  = 16'h0000;
  localparam logic [3:0]  IN_FILL    = 4'hF;
  localparam logic [7:0]  IN_IDLE    = 8'hFF;
  localparam logic [7:0]  ALL_EXP    = 8'hFF;
  localparam int          ST_WR_ERR  = 0;
  localparam int          ST_RD_ERR  = 1;
  typedef enum logic [1:0] {
    HPXM_IDLE  = 2'b00,
    HPXM_ISSUE = 2'b01,
    HPXM_WAIT  = 2'b10
  } hpxm_state_t;
  typedef enum logic [1:0] {
    HPXM_JOB_POLAR  = 2'b00,
    HPXM_JOB_WRITE  = 2'b01,
    HPXM_JOB_CONFIG = 2'b10,
    HPXM_JOB_READ   = 2'b11
  } hpxm_job_t;
endpackage : hpxm_pkg

`timescale 1ns/1ns
`default_nettype none
module hpxm_sync (
  input  wire logic clk,     // Core clock
  input  wire logic resetn,  // Async reset, active low
  input  wire logic d,       // Asynchronous level
  output logic      q        // Synchronised level
);
  logic meta_q;
  // Idle high so a released open-drain line reads inactive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : hpxm_sync
`default_nettype wire

// File: verif/hpxm_exp_model.sv
`timescale 1ns/1ns
`default_nettype none
module hpxm_exp_model #(
  parameter int GAP = 200  // Least write spacing in cycles
) (
  input  wire logic         clk,        // Core clock
  input  wire logic         resetn,     // Reset, active low
  input  wire logic         slow,       // Answer slowly
  input  wire logic         err_en,     // Fail every transfer
  input  wire logic [127:0] pins,       // Input pin levels
  input  wire logic         cmd_valid,  // Request
  output logic              cmd_ready,  // Request taken
  input  wire logic         cmd_write,  // Write
  input  wire logic [6:0]   cmd_addr,   // Address
  input  wire logic [7:0]   cmd_reg,    // Register
  input  wire logic [15:0]  cmd_data,   // Write data
  output logic              rsp_valid,  // Done
  output logic              rsp_error,  // Failed
  output logic [15:0]       rsp_data,   // Read data
  output logic              irq_n,      // Shared interrupt
  output logic [127:0]      out_w,      // Output registers
  output logic [127:0]      pol_w,      // Polarity registers
  output logic [127:0]      cfg_w,      // Config registers
  output logic [15:0]       rd_cnt,     // Reads done
  output logic [7:0]        viol        // Writes too close
);
  logic [127:0] seen_q;
  logic [3:0]   cnt_q;
  logic [1:0]   ph_q;
  logic [2:0]   e_q;
  logic         w_q;
  logic [7:0]   r_q;
  logic [15:0]  d_q;
  logic [31:0]  now_q;
  logic [31:0]  last_q [8];
  logic [3:0]   dly;
  assign dly   = slow ? 4'h9 : 4'h1;
  assign irq_n = ~|((pins ^ seen_q) & cfg_w);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {cmd_ready, rsp_valid, rsp_error, w_q, ph_q, cnt_q, e_q} <= '0;
      {r_q, d_q, rsp_data, rd_cnt, viol, now_q} <= '0;
      {out_w, pol_w, cfg_w, seen_q} <= '1;
      for (int i = 0; i < 8; i++) last_q[i] <= 32'hF000_0000;
    end else begin
      now_q     <= now_q + 1;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      if (rsp_valid) rsp_data <= ~rsp_data;  // Released bus never keeps its value
      case (ph_q)
        2'd0: if (cmd_valid) begin
          cnt_q <= cnt_q + 1;
          if (cnt_q >= dly) begin
            {cmd_ready, ph_q, cnt_q} <= {1'b1, 2'd1, 4'h0};
          end
        end
        2'd1: begin
          {e_q, w_q, r_q, d_q} <= {cmd_addr[2:0], cmd_write, cmd_reg, cmd_data};
          ph_q <= 2'd2;
        end
        default: begin
          cnt_q <= cnt_q + 1;
          if (cnt_q >= dly) begin
            {ph_q, cnt_q, rsp_valid, rsp_error} <= {2'd0, 4'h0, 1'b1, err_en};
            rsp_data <= (pins[e_q*16+:16] & cfg_w[e_q*16+:16]) |
                        (out_w[e_q*16+:16] & ~cfg_w[e_q*16+:16]);
            if (!err_en && w_q && r_q == 8'h02) begin
              out_w[e_q*16+:16] <= d_q;
              last_q[e_q]       <= now_q;
              if (now_q - last_q[e_q] < GAP) viol <= viol + 1;
            end
            if (!err_en && w_q && r_q == 8'h04) pol_w[e_q*16+:16] <= d_q;
            if (!err_en && w_q && r_q == 8'h06) cfg_w[e_q*16+:16] <= d_q;
            if (!err_en && !w_q) begin
              seen_q[e_q*16+:16] <= pins[e_q*16+:16];
              rd_cnt             <= rd_cnt + 1;
            end
          end
        end
      endcase
    end
  end
endmodule : hpxm_exp_model
`default_nettype wire

// File: verif/hotplug_io_expander_manager_tb.sv
`timescale 1ns/1ns
`default_nettype none
module hotplug_io_expander_manager_tb;
  typedef struct packed {int s; logic [3:0] v;} hpxm_row_t;
  logic clk = 0, resetn = 0, irq_n, alt = 1, frst = 0, acv = 1, slow = 0, err_en = 0;
  logic [55:0]  exp_addr;
  logic [15:0]  ai = '0, pi = '0, pe = '0, rn = '0, btn, pres, flt, good, cdat, rdat, rd_cnt;
  logic [127:0] pins = '1, out_w, pol_w, cfg_w;
  logic         cv, cr, cw, rv, re;
  logic [6:0]   cad;
  logic [7:0]   creg, viol;
  logic [1:0]   sclr = '0, st;
  int           fails = 0, samples_checked = 0, c;
  hpxm_row_t    rows [6] = '{'{0, 4'hA}, '{2, 4'h5}, '{15, 4'hF}, '{5, 4'h3},
                             '{9, 4'h6}, '{12, 4'h9}};
  always #20 clk = ~clk;
  hpxm_top #(.UPDATE_CYC(20'h0_00C8)) u_hpxm_top (.clk(clk), .resetn(resetn),
    .expander_irq_n(irq_n), .gpio_alt_mode(alt), .fund_rst(frst), .addr_cfg_valid(acv),
    .exp_addr(exp_addr), .slot_attn_indicator(ai), .slot_power_indicator(pi),
    .slot_power_enable(pe), .slot_reset_n(rn), .slot_attn_button_n(btn),
    .slot_presence_n(pres), .slot_power_fault_n(flt), .slot_power_good_n(good),
    .cmd_valid(cv), .cmd_ready(cr), .cmd_write(cw), .cmd_addr(cad), .cmd_reg(creg),
    .cmd_data(cdat), .rsp_valid(rv), .rsp_error(re), .rsp_data(rdat),
    .status_clr(sclr), .smbus_status_reg(st));
  hpxm_exp_model #(.GAP(200)) u_hpxm_exp_model (.clk(clk), .resetn(resetn), .slow(slow),
    .err_en(err_en), .pins(pins), .cmd_valid(cv), .cmd_ready(cr), .cmd_write(cw),
    .cmd_addr(cad), .cmd_reg(creg), .cmd_data(cdat), .rsp_valid(rv), .rsp_error(re),
    .rsp_data(rdat), .irq_n(irq_n), .out_w(out_w), .pol_w(pol_w), .cfg_w(cfg_w),
    .rd_cnt(rd_cnt), .viol(viol));
  function automatic logic [15:0] word(int e);
    int x;
    x = (e / 2) * 4 + e % 2;
    return {rn[x+2], pe[x+2], pi[x+2], ai[x+2], 4'hF, rn[x], pe[x], pi[x], ai[x], 4'hF};
  endfunction : word
  task automatic chk(string n, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wait_out(int e);
    for (int i = 0; i < 1500 && out_w[e*16+:16] !== word(e); i++) @(posedge clk);
    chk("out_word", word(e), out_w[e*16+:16]);
  endtask : wait_out
  task automatic wait_rd(int n);
    for (int i = 0; i < 3000 && rd_cnt < n; i++) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask : wait_rd
  task automatic chk_all;
    int x;
    for (int e = 0; e < 8; e++) begin
      x = (e / 2) * 4 + e % 2;
      chk("polarity", 16'h0000, pol_w[e*16+:16]);
      chk("config", 16'h0F0F, cfg_w[e*16+:16]);
      chk("out_word", word(e), out_w[e*16+:16]);
      chk("inputs", {8'h00, pins[e*16+8+:4], pins[e*16+:4]}, {8'h00, good[x+2], flt[x+2],
          pres[x+2], btn[x+2], good[x], flt[x], pres[x], btn[x]});
    end
  endtask : chk_all
  task automatic final_report;
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #(40 * 40000);
    fails++;
    final_report();
  end
  initial begin
    for (int e = 0; e < 8; e++) exp_addr[e*7+:7] = 7'h20 + 7'(e);
    repeat (16) @(posedge clk);
    chk("reset_in", 16'hFFFF, pres);
    chk("reset_cmd", 16'h0000, {cv, 13'h0000, st});
    resetn <= 1'b1;
    wait_rd(8);
    chk_all();
    for (int r = 0; r < 6; r++) begin
      @(posedge clk);
      {rn[rows[r].s], pe[rows[r].s], pi[rows[r].s], ai[rows[r].s]} <= rows[r].v;
      @(posedge clk);
      wait_out((rows[r].s / 4) * 2 + rows[r].s % 2);
    end
    chk("spacing", 16'h0000, {8'h00, viol});
    // Sweep on interrupt: every expander read, not just the one that changed
    c = rd_cnt;
    pins[49] <= 1'b0;
    wait_rd(c + 8);
    chk("sweep", 16'(c + 8), rd_cnt);
    chk("presence", 16'h0000, {15'h0000, pres[5]});
    c = rd_cnt;
    pins[57] <= 1'b0;
    repeat (30) @(posedge clk);
    chk("read_gap", 16'(c), rd_cnt);
    wait_rd(c + 8);
    chk("presence", 16'h0000, {15'h0000, pres[7]});
    alt <= 1'b0;
    c = rd_cnt;
    pins[50] <= 1'b0;
    repeat (400) @(posedge clk);
    chk("alt_off", 16'(c), rd_cnt);
    alt <= 1'b1;
    wait_rd(c + 8);
    chk("fault", 16'h0000, {15'h0000, flt[5]});
    slow <= 1'b1;
    err_en <= 1'b1;
    ai[0] <= ~ai[0];
    for (int i = 0; i < 1500 && st[0] !== 1'b1; i++) @(posedge clk);
    chk("wr_err", 16'h0001, {14'h0000, st});
    err_en <= 1'b0;
    wait_out(0);
    sclr <= 2'b01;
    @(posedge clk);
    sclr <= 2'b00;
    @(posedge clk);
    chk("clr", 16'h0000, {14'h0000, st});
    // Failed sweep: read error recorded, old inputs kept until a good read
    slow <= 1'b0;
    err_en <= 1'b1;
    c = rd_cnt;
    pins[65] <= 1'b0;
    for (int i = 0; i < 1500 && st[1] !== 1'b1; i++) @(posedge clk);
    repeat (100) @(posedge clk);
    chk("rd_err", 16'h0002, {14'h0000, st});
    chk("rd_keep", 16'h0001, {15'h0000, pres[8]});
    err_en <= 1'b0;
    wait_rd(c + 8);
    chk("rd_retry", 16'h0000, {15'h0000, pres[8]});
    repeat (250) @(posedge clk);
    frst <= 1'b1;
    c = out_w[31:16];
    repeat (5) @(posedge clk);
    ai[1] <= ~ai[1];
    repeat (5) @(posedge clk);
    pe[3] <= ~pe[3];
    rn[1] <= ~rn[1];
    repeat (400) @(posedge clk);
    chk("hold", 16'(c), out_w[31:16]);
    c = rd_cnt;
    frst <= 1'b0;
    wait_rd(c + 8);
    chk_all();
    final_report();
  end
endmodule : hotplug_io_expander_manager_tb
`default_nettype wire
